// [hdl/ccdp_loader.sv]
// volatile configuration loader and clock plan for the generator
// Functional notes
// - after final write accepted, outputs run per loaded plan
// - first write 0x01 to 0x06 enters ready mode
// - last write 0x02 to 0x06 returns to active mode
// - register address is eight bits, one per write
// - one eight-bit data byte stored at the addressed register
// - VCO equals reference times feedback ratio
// - input chosen by mux select field or select pins
// - five integer and two fractional dividers feed groups
// - output = VCO over group divider times output R divider
// - twelve-output group map: 0/1-2/3-5/6-8/9/10-11
// - input pin assignments unaffected by downloads
`timescale 1ns/10ps
`default_nettype none
module ccdp_loader
  import ccdp_pkg::*;
#(
  parameter int NUM_HSDIV = CCDP_NUM_HSDIV,
  parameter int NUM_ID = CCDP_NUM_ID,
  parameter int NUM_OUT = CCDP_NUM_OUT,
  parameter bit HAS_SEL_PINS = 1'b1
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic wr_valid_i,
  input wire logic [7:0] wr_addr_i,
  input wire logic [7:0] wr_data_i,
  input wire logic [1:0] input_select_pins_i,
  input wire logic sel_pins_enable_i,
  output logic ready_mode_o,
  output logic active_mode_o,
  output logic [1:0] active_input_o,
  output logic [7:0] pdiv_o,
  output logic [7:0] loop_mode_o,
  output logic [CCDP_FB_W-1:0] feedback_integer_field_o,
  output logic [CCDP_FB_W-1:0] feedback_residue_field_o,
  output logic [CCDP_FB_W-1:0] feedback_denominator_field_o,
  output logic [NUM_OUT-1:0] clk_out_o
);
  ccdp_state_t state_q;
  ccdp_state_t state_d;
  logic [7:0] regs_q [256];
  logic [1:0] sel_q;
  logic is_ctrl;
  logic go_ready;
  logic go_active;
  logic run;
  logic [NUM_OUT-1:0] clk_raw;

  assign is_ctrl = wr_valid_i && (wr_addr_i == CCDP_CTRL_ADDR);
  assign go_ready = is_ctrl && (wr_data_i == CCDP_CTRL_READY);
  assign go_active = is_ctrl && (wr_data_i == CCDP_CTRL_ACTIVE);
  assign run = (state_q == CCDP_ACTIVE);

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      CCDP_BLANK, CCDP_ACTIVE: begin
        if (go_ready) begin
          state_d = CCDP_READY;
        end
      end
      CCDP_READY: begin
        if (go_active) begin
          state_d = CCDP_ACTIVE;
        end
      end
      default: begin
        state_d = CCDP_BLANK;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      state_q <= CCDP_BLANK;
    end else begin
      state_q <= state_d;
    end
  end

  // storage of each pair except control writes to 0x06; plan stays frozen outside ready mode
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      for (int i = 0; i < 256; i++) begin
        regs_q[i] <= CCDP_DIV_RESET;
      end
    end else if (wr_valid_i && !is_ctrl && state_q == CCDP_READY) begin
      regs_q[wr_addr_i] <= wr_data_i;
    end
  end

  // pin enable is a strap, not loadable by a download
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      sel_q <= 2'b00;
    end else if (HAS_SEL_PINS && sel_pins_enable_i) begin
      sel_q <= input_select_pins_i;
    end else begin
      sel_q <= regs_q[CCDP_IMUX_ADDR][1:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      ready_mode_o <= 1'b0;
      active_mode_o <= 1'b0;
      active_input_o <= 2'b00;
      pdiv_o <= CCDP_DIV_RESET;
      loop_mode_o <= CCDP_DIV_RESET;
      feedback_integer_field_o <= '0;
      feedback_residue_field_o <= '0;
      feedback_denominator_field_o <= '0;
      clk_out_o <= '0;
    end else begin
      ready_mode_o <= (state_q == CCDP_READY);
      active_mode_o <= run;
      active_input_o <= sel_q;
      pdiv_o <= regs_q[CCDP_PDIV_ADDR];
      loop_mode_o <= regs_q[CCDP_MODE_ADDR];
      // ratio held as 15-bit fixed point fields
      feedback_integer_field_o <= {regs_q[CCDP_FBI_ADDR + 8'h01][6:0], regs_q[CCDP_FBI_ADDR]};
      feedback_residue_field_o <= {regs_q[CCDP_FBR_ADDR + 8'h01][6:0], regs_q[CCDP_FBR_ADDR]};
      feedback_denominator_field_o <= {regs_q[CCDP_FBD_ADDR + 8'h01][6:0],
                                       regs_q[CCDP_FBD_ADDR]};
      clk_out_o <= clk_raw;
    end
  end

  // group of each output on the twelve-output part
  function automatic logic [2:0] grp_of(input int o);
    case (o)
      0: grp_of = 3'd0;
      1, 2: grp_of = 3'd1;
      3, 4, 5: grp_of = 3'd2;
      6, 7, 8: grp_of = 3'd3;
      9: grp_of = 3'd4;
      default: grp_of = 3'd5;
    endcase
  endfunction

  // per output: group source picks one of five integer or two fractional dividers
  for (genvar o = 0; o < NUM_OUT; o++) begin : g_out
    logic [2:0] grp;
    logic [2:0] src;
    logic [7:0] gdiv;
    assign grp = grp_of(o);
    assign src = regs_q[CCDP_GSEL_ADDR + 8'(grp)][2:0];
    // sources 0..4 integer, 5..6 fractional integer part
    assign gdiv = (src < 3'(NUM_HSDIV)) ? regs_q[CCDP_HSDIV_ADDR + 8'(src)] :
                  (src < 3'(NUM_HSDIV + NUM_ID)) ?
                  regs_q[CCDP_ID_ADDR + 8'(src) - 8'(NUM_HSDIV)] : 8'h00;
    ccdp_out_divider u_div (
      .clk_i(clk_i),
      .reset_i(reset_i),
      .run_i(run),
      .div_i(gdiv),
      .rdiv_i(regs_q[CCDP_RDIV_ADDR + 8'(o)][5:0]),
      .clk_o(clk_raw[o])
    );
  end
endmodule
`default_nettype wire

// [hdl/ccdp_pkg.sv]
// constants for the clock configuration download planner
package ccdp_pkg;
  localparam logic [7:0] CCDP_CTRL_ADDR = 8'h06;
  localparam logic [7:0] CCDP_CTRL_READY = 8'h01;
  localparam logic [7:0] CCDP_CTRL_ACTIVE = 8'h02;
  localparam logic [7:0] CCDP_IMUX_ADDR = 8'h17;
  localparam logic [7:0] CCDP_PDIV_ADDR = 8'h18;
  localparam logic [7:0] CCDP_MODE_ADDR = 8'h19;
  localparam logic [7:0] CCDP_FBI_ADDR = 8'h1a;
  localparam logic [7:0] CCDP_FBR_ADDR = 8'h1c;
  localparam logic [7:0] CCDP_FBD_ADDR = 8'h1e;
  localparam logic [7:0] CCDP_HSDIV_ADDR = 8'h20;
  localparam logic [7:0] CCDP_ID_ADDR = 8'h25;
  localparam logic [7:0] CCDP_GSEL_ADDR = 8'h27;
  localparam logic [7:0] CCDP_RDIV_ADDR = 8'h30;
  localparam int CCDP_FB_W = 15;
  localparam int CCDP_NUM_HSDIV = 5;
  localparam int CCDP_NUM_ID = 2;
  localparam int CCDP_NUM_GRP = 6;
  localparam int CCDP_NUM_OUT = 12;
  localparam logic [7:0] CCDP_DIV_RESET = 8'h00;
  typedef enum logic [1:0] {CCDP_BLANK, CCDP_READY, CCDP_ACTIVE} ccdp_state_t;
endpackage

// [hdl/ccdp_out_divider.sv]
// one output divider: group divide times per-output divide
`timescale 1ns/10ps
`default_nettype none
module ccdp_out_divider (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic run_i,
  input wire logic [7:0] div_i,
  input wire logic [5:0] rdiv_i,
  output logic clk_o
);
  logic [13:0] cnt_q;
  logic [13:0] cnt_d;
  logic clk_q;
  logic [13:0] total;
  logic ok;
  logic wrap;
  assign total = 14'(div_i) * 14'(rdiv_i);
  assign ok = run_i && (div_i != 8'h00) && (rdiv_i != 6'h00);
  assign wrap = (cnt_q >= total - 14'h0001);
  assign cnt_d = (!ok || wrap) ? 14'h0000 : cnt_q + 14'h0001;
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      cnt_q <= 14'h0000;
      clk_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      // toggle at half-period marks
      clk_q <= !ok ? 1'b0 : (wrap ? 1'b0 : ((cnt_q == (total >> 1) - 14'h0001) ? 1'b1 : clk_q));
    end
  end
  assign clk_o = clk_q;
endmodule
`default_nettype wire

// [test/ccdp_loader_checker.sv]
// port assertions for the configuration loader
`timescale 1ns/10ps
`default_nettype none
module ccdp_loader_checker
  import ccdp_pkg::*;
#(parameter int NUM_OUT = CCDP_NUM_OUT) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic wr_valid_i,
  input wire logic [7:0] wr_addr_i,
  input wire logic [7:0] wr_data_i,
  input wire logic [1:0] input_select_pins_i,
  input wire logic sel_pins_enable_i,
  input wire logic ready_mode_o,
  input wire logic active_mode_o,
  input wire logic [1:0] active_input_o,
  input wire logic [7:0] pdiv_o,
  input wire logic [NUM_OUT-1:0] clk_out_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  wire ctl = wr_valid_i && wr_addr_i == CCDP_CTRL_ADDR;
  wire go_rdy = ctl && wr_data_i == CCDP_CTRL_READY;
  wire go_act = ctl && wr_data_i == CCDP_CTRL_ACTIVE && ready_mode_o;
  wire pdw = wr_valid_i && wr_addr_i == CCDP_PDIV_ADDR;
  a_ready_entry: assert property (go_rdy |-> ##2 ready_mode_o) else $error("no ready");
  a_active_entry: assert property (go_act && !$past(wr_valid_i) |-> ##2 active_mode_o)
    else $error("no active");
  a_ready_exit: assert property (go_act && !$past(wr_valid_i) |-> ##2 !ready_mode_o)
    else $error("ready kept");
  a_modes_apart: assert property (!(ready_mode_o && active_mode_o))
    else $error("two modes");
  a_clk_quiet: assert property (!active_mode_o [*2] |-> clk_out_o == '0)
    else $error("clk");
  a_pdiv_held: assert property (pdw && !ready_mode_o && !$past(wr_valid_i) |->
    ##2 $stable(pdiv_o)) else $error("pdiv changed");
  a_pdiv_load: assert property (pdw && ready_mode_o && !$past(wr_valid_i) |->
    ##2 pdiv_o == $past(wr_data_i, 2)) else $error("pdiv lost");
  a_pin_pick: assert property ((sel_pins_enable_i && $stable(input_select_pins_i)) [*4] |->
    active_input_o == input_select_pins_i) else $error("pins ignored");
  c_ready: cover property (go_rdy);
  c_active: cover property (go_act);
  c_clk: cover property (active_mode_o && clk_out_o[0]);
endmodule
`default_nettype wire

// [test/ccdp_host_model.sv]
// host model: writes address/data pairs
`timescale 1ns/10ps
`default_nettype none
module ccdp_host_model (
  input wire logic clk_i,
  output var logic wr_valid_o = 1'b0,
  output var logic [7:0] wr_addr_o = 8'h00,
  output var logic [7:0] wr_data_o = 8'h00
);
  // gap 0 keeps valid up for a back-to-back pair
  // no refusal on this port: a pair is taken at the edge that sees valid
  task put(input logic [7:0] a, input logic [7:0] d, input int gap);
    @(negedge clk_i);
    wr_valid_o = 1'b1;
    wr_addr_o = a;
    wr_data_o = d;
    if (gap > 0) begin
      @(negedge clk_i);
      wr_valid_o = 1'b0;
      wr_addr_o = ~a;
      wr_data_o = ~d;
      repeat (gap - 1) @(negedge clk_i);
    end
  endtask
endmodule
`default_nettype wire

// [test/ccdp_loader_tb.sv]
// self-checking bench for the configuration loader
`timescale 1ns/10ps
`default_nettype none
module ccdp_loader_tb import ccdp_pkg::*;;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic sel_en = 1'b0;
  logic [1:0] pins = 2'h0;
  logic vld, rdy, act;
  logic [7:0] adr, dat, pdiv, mode;
  logic [1:0] ain;
  logic [14:0] fbi, fbr, fbd;
  logic [11:0] clko;
  logic [7:0] a[15], d[15];
  logic [2:0] p;
  logic [14:0] fbx;
  int fail_count = 0;
  int compares = 0;
  int rises[3] = '{0, 0, 0};
  always #2.5 clk_i = ~clk_i;
  ccdp_host_model ccdp_host_model_i (.clk_i(clk_i), .wr_valid_o(vld), .wr_addr_o(adr),
    .wr_data_o(dat));
  ccdp_loader ccdp_loader_i (.clk_i(clk_i), .reset_i(reset_i), .wr_valid_i(vld),
    .wr_addr_i(adr), .wr_data_i(dat), .input_select_pins_i(pins), .sel_pins_enable_i(sel_en),
    .ready_mode_o(rdy), .active_mode_o(act), .active_input_o(ain), .pdiv_o(pdiv),
    .loop_mode_o(mode), .feedback_integer_field_o(fbi), .feedback_residue_field_o(fbr),
    .feedback_denominator_field_o(fbd), .clk_out_o(clko));
  task chk(input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      fail_count++;
      $display("[ERR] %0t seen %h exp %h", $time, s, e);
    end
  endtask
  task give_verdict;
    if (fail_count == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task put(input logic [7:0] x, input logic [7:0] y, input int g);
    ccdp_host_model_i.put(x, y, g);
    repeat (2) @(negedge clk_i);
  endtask
  function logic [14:0] fb15(input logic [7:0] lo, input logic [7:0] hi);
    return {hi[6:0], lo};
  endfunction
  // integer field for a 2500 MHz vco from a 100 MHz input over p
  function automatic logic [14:0] plan_int(input logic [7:0] pd);
    return 15'(32'd3200 * pd);
  endfunction
  // rising edges seen in 160 cycles: period is div times r
  function automatic int rises_in(input logic [7:0] dv, input logic [7:0] r);
    return 160 / (int'(dv) * int'(r));
  endfunction
  initial begin
    #200000;
    fail_count++;
    give_verdict;
  end
  initial begin
    void'($urandom(32'hc4c14d7b));
    a = '{CCDP_IMUX_ADDR, CCDP_PDIV_ADDR, CCDP_MODE_ADDR, CCDP_FBI_ADDR, CCDP_FBI_ADDR + 8'h01,
      CCDP_FBR_ADDR, CCDP_FBR_ADDR + 8'h01, CCDP_FBD_ADDR, CCDP_HSDIV_ADDR, CCDP_GSEL_ADDR,
      CCDP_RDIV_ADDR, CCDP_ID_ADDR, CCDP_GSEL_ADDR + 8'h01, CCDP_RDIV_ADDR + 8'h01,
      CCDP_RDIV_ADDR + 8'h02};
    d[0] = 8'($urandom_range(3, 0));
    d[1] = 8'($urandom_range(10, 2));
    d[2] = (d[1] > 8'h06) ? 8'h01 : ((d[1] > 8'h03) ? 8'h04 : 8'h07);
    fbx = plan_int(d[1]);
    d[3] = fbx[7:0];
    d[4] = {1'b0, fbx[14:8]};
    d[7] = 8'($urandom_range(255, 2));
    d[5] = 8'($urandom_range(int'(d[7]) - 1, 0));
    d[6] = 8'h00;
    d[8] = 8'h08;
    d[9] = 8'h00;
    d[10] = 8'h01;
    d[11] = 8'h0a;
    d[12] = 8'h05;
    d[13] = 8'h01;
    d[14] = 8'h02;
    repeat (3) @(negedge clk_i);
    reset_i = 1'b0;
    put(CCDP_PDIV_ADDR, 8'hff, 1);
    chk(pdiv, 8'h00);
    put(CCDP_CTRL_ADDR, CCDP_CTRL_READY, 1);
    chk({rdy, act}, 2'b10);
    foreach (a[i]) ccdp_host_model_i.put(a[i], d[i], (i + 1) % 2);
    repeat (3) @(negedge clk_i);
    chk(pdiv, d[1]);
    chk(mode, d[2]);
    chk(fbi, plan_int(d[1]));
    chk(fbr, fb15(d[5], d[6]));
    chk(fbd, fb15(d[7], 8'h00));
    chk(ain, d[0][1:0]);
    put(CCDP_CTRL_ADDR, CCDP_CTRL_ACTIVE, 1);
    chk({rdy, act}, 2'b01);
    repeat (160) begin
      p = clko[2:0];
      @(negedge clk_i);
      for (int k = 0; k < 3; k++) begin
        rises[k] += int'(!p[k] && clko[k]);
      end
    end
    chk(rises[0], rises_in(d[8], d[10]));
    chk(rises[1], rises_in(d[11], d[13]));
    chk(rises[2], rises_in(d[11], d[14]));
    chk(clko[11:3], 9'h000);
    put(CCDP_PDIV_ADDR, ~d[1], 1);
    chk(pdiv, d[1]);
    sel_en = 1'b1;
    pins = 2'($urandom);
    repeat (5) @(negedge clk_i);
    chk(ain, pins);
    give_verdict;
  end
endmodule
bind ccdp_loader ccdp_loader_checker #(.NUM_OUT(NUM_OUT)) ccdp_loader_checker_i (
  .clk_i(clk_i), .reset_i(reset_i), .wr_valid_i(wr_valid_i), .wr_addr_i(wr_addr_i),
  .wr_data_i(wr_data_i), .input_select_pins_i(input_select_pins_i),
  .sel_pins_enable_i(sel_pins_enable_i), .ready_mode_o(ready_mode_o),
  .active_mode_o(active_mode_o), .active_input_o(active_input_o), .pdiv_o(pdiv_o),
  .clk_out_o(clk_out_o));
`default_nettype wire
